// ===== core/video_tap_consts.svh
// named constants shared by the stream tap monitor and the trace collector
// Operation
// - one shared clock for monitor and collector
// - collector clocked from same source, no crossing
// - reset clears debug state only, not stream
// - monitor reset driven by collector reset output
// - downstream raises ready when it can accept
// - output valid marks every presented beat
// - output start flag marks first packet beat
// - output end flag marks last packet beat
// - word 0 returns maker and type identity
// - words 1 to 3 hold tooling configuration
// - enable plus statistics bit sends counters
// - enable plus sampling bit sends up to six beats
// - enable cleared stops new captures, not one going out
// - stream passes unchanged, undelayed, never stalled
// - count four ready/valid cycle kinds in packet
// - count valid-only and ready-only cycles between packets
`ifndef VIDEO_TAP_CONSTS_SVH
`define VIDEO_TAP_CONSTS_SVH

// monitor register words on the control port
`define REG_AW 3
`define REG_ID 3'h0
`define REG_CFG_A 3'h1
`define REG_CFG_B 3'h2
`define REG_CFG_C 3'h3
`define REG_CTRL 3'h4
// identity values are arbitrary
`define ID_MAKER 12'hA5C
`define ID_TYPE 16'h3D1
// tooling words: opaque, arbitrary contents
`define CFG_A_VAL 32'h0000_0018
`define CFG_B_VAL 32'h0000_0020
`define CFG_C_VAL 32'h0000_0006
`define CTRL_EN_BIT 0
`define CTRL_STAT_BIT 8
`define CTRL_SMP_BIT 9

// widths
`define VID_W 24
`define CAP_W 32
`define CAP_EMPTY_W 2
`define BE_W 4
`define FIFO_W 36
`define FIFO_DEPTH 8

// capture packet layout
`define N_STAT 6
`define N_SMP 6
`define N_WORDS 12
`define REM_W 4
`define IDX_W 3
`define STAT_REM 4'h6
`define SMP_MAX 3'h6

// collector APB register offsets
`define APB_AW 8
`define APB_CMD 8'h00
`define APB_WDATA 8'h04
`define APB_STATUS 8'h08
`define APB_RDATA 8'h0C
`define APB_CAPTURE 8'h10
`define APB_SOFTRST 8'h14
`define CMD_WRITE_BIT 8

`endif

// ===== core/video_tap_pkg.sv
// types shared by the stream tap monitor and the trace collector
package video_tap_pkg;
   typedef logic [31:0] word_type;
   typedef enum logic [1:0] {
      SEND_IDLE = 2'b01,
      SEND_BUSY = 2'b10
   } send_state_type;
   typedef enum logic [2:0] {
      M_IDLE = 3'b001,
      M_REQ = 3'b010,
      M_RDWAIT = 3'b100
   } mst_state_type;
endpackage : video_tap_pkg

// ===== core/video_tap_if.sv
// carrier between monitor (control slave, capture source) and collector
`timescale 1ns/1ps
`include "video_tap_consts.svh"
interface video_tap_if;
   logic [`REG_AW-1:0] ctl_address;
   logic ctl_read;
   logic ctl_write;
   logic [31:0] ctl_writedata;
   logic [`BE_W-1:0] ctl_byteenable;
   logic [31:0] ctl_readdata;
   logic ctl_readdatavalid;
   logic ctl_waitrequest;
   logic [`CAP_W-1:0] cap_data;
   logic cap_valid;
   logic cap_ready;
   logic cap_sop;
   logic cap_eop;
   logic [`CAP_EMPTY_W-1:0] cap_empty;
   logic trace_rst_n;
   modport monitor (
      input ctl_address, ctl_read, ctl_write, ctl_writedata, ctl_byteenable,
      output ctl_readdata, ctl_readdatavalid, ctl_waitrequest,
      output cap_data, cap_valid, cap_sop, cap_eop, cap_empty,
      input cap_ready, trace_rst_n
   );
   modport collector (
      output ctl_address, ctl_read, ctl_write, ctl_writedata, ctl_byteenable,
      input ctl_readdata, ctl_readdatavalid, ctl_waitrequest,
      input cap_data, cap_valid, cap_sop, cap_eop, cap_empty,
      output cap_ready, trace_rst_n
   );
endinterface : video_tap_if

// ===== core/capture_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module capture_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   assign in_ready = (cnt_q != FULL_CNT);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
   // storage needs no reset: cnt_q guards every read
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule : capture_fifo

// ===== core/trace_collector.sv
// trace collector: APB command port, control master, capture sink
`timescale 1ns/1ps
`include "video_tap_consts.svh"
module trace_collector (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   video_tap_if.collector tap
);
   video_tap_pkg::mst_state_type mst_q;
   logic [`REG_AW-1:0] addr_q;
   logic is_wr_q;
   video_tap_pkg::word_type wdata_q;
   video_tap_pkg::word_type rdata_q;
   video_tap_pkg::word_type prdata_q;
   logic soft_q;
   logic trst_n_q;
   logic [`FIFO_W-1:0] head;
   logic head_valid;
   logic pop;
   logic cap_hit_q;

   wire setup = psel & ~penable;
   wire acc_wr = psel & penable & pwrite;
   wire acc_rd = psel & penable & ~pwrite;
   wire busy = (mst_q != video_tap_pkg::M_IDLE);
   wire go = acc_wr & (paddr == `APB_CMD) & ~busy;
   wire [31:0] status = {26'h0, head[`FIFO_W-1:`FIFO_W-2],
      head[`FIFO_W-3] & head_valid, head[`FIFO_W-4] & head_valid,
      head_valid, busy};
   wire [31:0] rd_mux =
      (paddr == `APB_CMD) ? {23'h0, is_wr_q, 5'h0, addr_q} :
      (paddr == `APB_WDATA) ? wdata_q :
      (paddr == `APB_STATUS) ? status :
      (paddr == `APB_RDATA) ? rdata_q :
      (paddr == `APB_CAPTURE) ? (head_valid ? head[31:0] : 32'h0) :
      (paddr == `APB_SOFTRST) ? {31'h0, soft_q} : 32'h0;

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = prdata_q;
   // pop only a head that the setup cycle already copied into prdata
   assign pop = acc_rd & (paddr == `APB_CAPTURE) & cap_hit_q;

   assign tap.ctl_address = addr_q;
   assign tap.ctl_writedata = wdata_q;
   assign tap.ctl_byteenable = {`BE_W{1'b1}};
   assign tap.ctl_write = (mst_q == video_tap_pkg::M_REQ) & is_wr_q;
   assign tap.ctl_read = (mst_q == video_tap_pkg::M_REQ) & ~is_wr_q;
   // same clk feeds the monitor; no crossing on any path
   assign tap.trace_rst_n = trst_n_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addr_q <= '0;
         is_wr_q <= 1'b0;
         wdata_q <= 32'h0;
         soft_q <= 1'b0;
         prdata_q <= 32'h0;
         trst_n_q <= 1'b0;
         cap_hit_q <= 1'b0;
      end else begin
         trst_n_q <= ~soft_q;
         if (setup) begin
            prdata_q <= rd_mux;
            cap_hit_q <= (paddr == `APB_CAPTURE) & head_valid;
         end
         if (go) begin
            addr_q <= pwdata[`REG_AW-1:0];
            is_wr_q <= pwdata[`CMD_WRITE_BIT];
         end
         if (acc_wr && paddr == `APB_WDATA) begin
            wdata_q <= pwdata;
         end
         if (acc_wr && paddr == `APB_SOFTRST) begin
            soft_q <= pwdata[0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mst_q <= video_tap_pkg::M_IDLE;
         rdata_q <= 32'h0;
      end else begin
         case (mst_q)
            video_tap_pkg::M_IDLE: begin
               if (go) begin
                  mst_q <= video_tap_pkg::M_REQ;
               end
            end
            video_tap_pkg::M_REQ: begin
               if (!tap.ctl_waitrequest) begin
                  mst_q <= is_wr_q ? video_tap_pkg::M_IDLE
                                   : video_tap_pkg::M_RDWAIT;
               end
            end
            video_tap_pkg::M_RDWAIT: begin
               if (tap.ctl_readdatavalid) begin
                  rdata_q <= tap.ctl_readdata;
                  mst_q <= video_tap_pkg::M_IDLE;
               end
            end
            default: mst_q <= video_tap_pkg::M_IDLE;
         endcase
      end
   end

   // full fifo drops cap_ready, which holds the monitor's beat in place
   capture_fifo #(.WIDTH(`FIFO_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_data({tap.cap_empty, tap.cap_sop, tap.cap_eop, tap.cap_data}),
      .in_valid(tap.cap_valid),
      .in_ready(tap.cap_ready),
      .out_data(head),
      .out_valid(head_valid),
      .out_ready(pop)
   );
endmodule : trace_collector

// ===== core/video_tap_monitor.sv
// stream tap monitor: pass-through, flow statistics, beat sampling
`timescale 1ns/1ps
`include "video_tap_consts.svh"
module video_tap_monitor (
   input wire logic clk,
   video_tap_if.monitor tap,
   input wire logic [`VID_W-1:0] din_data,
   input wire logic din_valid,
   input wire logic din_sop,
   input wire logic din_eop,
   output logic din_ready,
   output logic [`VID_W-1:0] dout_data,
   output logic dout_valid,
   output logic dout_sop,
   output logic dout_eop,
   input wire logic dout_ready
);
   // the one clk also runs the video path and the collector
   wire dbg_rst_n = tap.trace_rst_n;

   // ---- pass-through: pure wires, nothing here sees the debug reset
   assign dout_data = din_data;
   assign dout_valid = din_valid;
   assign dout_sop = din_sop;
   assign dout_eop = din_eop;
   assign din_ready = dout_ready;

   // ---- control slave
   logic en_q;
   logic stat_q;
   logic smp_q;
   video_tap_pkg::word_type rdata_q;
   logic rdv_q;

   wire wr_ctrl = tap.ctl_write & (tap.ctl_address == `REG_CTRL);
   wire [31:0] ctrl_word = {22'h0, smp_q, stat_q, 7'h0, en_q};
   wire [31:0] id_word = {4'h0, `ID_TYPE, `ID_MAKER};
   wire [31:0] rd_mux =
      (tap.ctl_address == `REG_ID) ? id_word :
      (tap.ctl_address == `REG_CFG_A) ? `CFG_A_VAL :
      (tap.ctl_address == `REG_CFG_B) ? `CFG_B_VAL :
      (tap.ctl_address == `REG_CFG_C) ? `CFG_C_VAL :
      (tap.ctl_address == `REG_CTRL) ? ctrl_word : 32'h0;

   assign tap.ctl_waitrequest = 1'b0;
   assign tap.ctl_readdata = rdata_q;
   assign tap.ctl_readdatavalid = rdv_q;

   always_ff @(posedge clk) begin
      if (!dbg_rst_n) begin
         en_q <= 1'b0;
         stat_q <= 1'b0;
         smp_q <= 1'b0;
         rdata_q <= 32'h0;
         rdv_q <= 1'b0;
      end else begin
         rdv_q <= tap.ctl_read;
         if (tap.ctl_read) begin
            rdata_q <= rd_mux;
         end
         // words 0 to 3 ignore writes
         if (wr_ctrl && tap.ctl_byteenable[0]) begin
            en_q <= tap.ctl_writedata[`CTRL_EN_BIT];
         end
         if (wr_ctrl && tap.ctl_byteenable[1]) begin
            stat_q <= tap.ctl_writedata[`CTRL_STAT_BIT];
            smp_q <= tap.ctl_writedata[`CTRL_SMP_BIT];
         end
      end
   end

   // ---- packet tracking
   logic in_pkt_q;
   wire xfer = din_valid & dout_ready;
   // a waiting start beat already belongs to its packet
   wire active = in_pkt_q | (din_valid & din_sop);
   wire sop_x = xfer & din_sop;
   wire eop_x = xfer & din_eop & active;

   always_ff @(posedge clk) begin
      if (!dbg_rst_n) begin
         in_pkt_q <= 1'b0;
      end else if (eop_x) begin
         in_pkt_q <= 1'b0;
      end else if (sop_x) begin
         in_pkt_q <= 1'b1;
      end
   end

   // ---- statistics counters; all restart once a packet ends
   logic [`N_STAT-1:0] inc;
   video_tap_pkg::word_type cnt_q [`N_STAT];
   video_tap_pkg::word_type snap_cnt [`N_STAT];

   assign inc[0] = active & din_valid & dout_ready;
   assign inc[1] = active & din_valid & ~dout_ready;
   assign inc[2] = active & ~din_valid & dout_ready;
   assign inc[3] = active & ~din_valid & ~dout_ready;
   assign inc[4] = ~active & din_valid & ~dout_ready;
   assign inc[5] = ~active & ~din_valid & dout_ready;

   // counters wrap at 32 bits; packets that long are out of scope
   genvar gi;
   generate
      for (gi = 0; gi < `N_STAT; gi++) begin : g_cnt
         assign snap_cnt[gi] = cnt_q[gi] + 32'(inc[gi]);
         always_ff @(posedge clk) begin
            if (!dbg_rst_n || eop_x) begin
               cnt_q[gi] <= 32'h0;
            end else begin
               cnt_q[gi] <= snap_cnt[gi];
            end
         end
      end
   endgenerate

   // ---- beat sampling
   logic [`IDX_W-1:0] smp_idx_q;
   logic [`VID_W-1:0] smp_q_mem [`N_SMP];
   video_tap_pkg::word_type snap_smp [`N_SMP];
   wire smp_store = xfer & active & (smp_idx_q < `SMP_MAX);
   wire [`IDX_W-1:0] n_smp = smp_idx_q + `IDX_W'(smp_store);

   always_ff @(posedge clk) begin
      if (!dbg_rst_n || eop_x) begin
         smp_idx_q <= '0;
      end else if (smp_store) begin
         smp_idx_q <= smp_idx_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (smp_store) begin
         smp_q_mem[smp_idx_q] <= din_data;
      end
   end

   generate
      for (gi = 0; gi < `N_SMP; gi++) begin : g_snap
         // the closing beat is taken straight from the bus
         assign snap_smp[gi] = (smp_store && smp_idx_q == `IDX_W'(gi))
            ? {8'h0, din_data} : {8'h0, smp_q_mem[gi]};
      end
   endgenerate

   // ---- capture sequencer
   video_tap_pkg::send_state_type st_q;
   video_tap_pkg::word_type snd_q [`N_WORDS];
   video_tap_pkg::word_type pack [`N_WORDS];
   logic [`REM_W-1:0] rem_q;
   logic first_q;
   logic last_q;

   wire want_stat = en_q & stat_q;
   wire want_smp = en_q & smp_q;
   wire idle = (st_q == video_tap_pkg::SEND_IDLE);
   // a packet that ends while a capture is still going out is skipped
   wire start = eop_x & idle & (want_stat | want_smp);
   wire [`REM_W-1:0] rem_load = (want_stat ? `STAT_REM : 4'h0)
      + (want_smp ? {1'b0, n_smp} : 4'h0);
   wire take = (st_q == video_tap_pkg::SEND_BUSY) & tap.cap_ready;

   generate
      for (gi = 0; gi < `N_WORDS; gi++) begin : g_pack
         if (gi < `N_STAT) begin : g_lo
            assign pack[gi] = stat_q ? snap_cnt[gi] : snap_smp[gi];
         end else begin : g_hi
            assign pack[gi] = stat_q ? snap_smp[gi - `N_STAT] : 32'h0;
         end
      end
   endgenerate

   assign tap.cap_valid = (st_q == video_tap_pkg::SEND_BUSY);
   assign tap.cap_data = snd_q[0];
   assign tap.cap_sop = first_q;
   assign tap.cap_eop = last_q;
   assign tap.cap_empty = '0;

   always_ff @(posedge clk) begin
      if (!dbg_rst_n) begin
         st_q <= video_tap_pkg::SEND_IDLE;
         rem_q <= '0;
         first_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         case (st_q)
            video_tap_pkg::SEND_IDLE: begin
               if (start) begin
                  st_q <= video_tap_pkg::SEND_BUSY;
                  rem_q <= rem_load;
                  first_q <= 1'b1;
                  last_q <= (rem_load == 4'h1);
               end
            end
            video_tap_pkg::SEND_BUSY: begin
               // beat and flags move only on acceptance
               if (take) begin
                  rem_q <= rem_q - 1'b1;
                  first_q <= 1'b0;
                  last_q <= (rem_q == 4'h2);
                  if (rem_q == 4'h1) begin
                     st_q <= video_tap_pkg::SEND_IDLE;
                  end
               end
            end
            default: st_q <= video_tap_pkg::SEND_IDLE;
         endcase
      end
   end

   // snapshot and shift register; held while cap_ready is low
   always_ff @(posedge clk) begin
      if (!dbg_rst_n) begin
         for (int i = 0; i < `N_WORDS; i++) begin
            snd_q[i] <= 32'h0;
         end
      end else if (start) begin
         for (int i = 0; i < `N_WORDS; i++) begin
            snd_q[i] <= pack[i];
         end
      end else if (take) begin
         for (int i = 0; i < `N_WORDS - 1; i++) begin
            snd_q[i] <= snd_q[i + 1];
         end
         snd_q[`N_WORDS - 1] <= 32'h0;
      end
   end
endmodule : video_tap_monitor

// ===== tb/video_tap_checker.sv
// assertions on the carrier between collector and monitor
`timescale 1ns/1ps
`include "video_tap_consts.svh"
module video_tap_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic trace_rst_n,
   input wire logic [`REG_AW-1:0] ctl_address,
   input wire logic ctl_read,
   input wire logic ctl_write,
   input wire logic [31:0] ctl_writedata,
   input wire logic [`BE_W-1:0] ctl_byteenable,
   input wire logic [31:0] ctl_readdata,
   input wire logic ctl_readdatavalid,
   input wire logic ctl_waitrequest,
   input wire logic [`CAP_W-1:0] cap_data,
   input wire logic cap_valid,
   input wire logic cap_ready,
   input wire logic cap_sop,
   input wire logic cap_eop,
   input wire logic [`CAP_EMPTY_W-1:0] cap_empty
);
   logic [3:0] words_q;
   logic known_q;
   logic [31:0] ctrl_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!trace_rst_n);
   // position inside the capture packet, counted from accepted words
   always_ff @(posedge clk) begin
      if (!trace_rst_n) begin
         words_q <= 4'h0;
      end else if (cap_valid && cap_ready) begin
         words_q <= cap_eop ? 4'h0 : words_q + 4'h1;
      end
   end
   // shadow of the control word; unknown until software first writes it
   always_ff @(posedge clk) begin
      if (!trace_rst_n) begin
         known_q <= 1'b0;
      end else if (ctl_write && ctl_address == `REG_CTRL) begin
         known_q <= 1'b1;
         ctrl_q <= {22'h0, ctl_writedata[9:8], 7'h0, ctl_writedata[0]};
      end
   end
   a_read_answer: assert property (ctl_read |=> ctl_readdatavalid ##1
      !ctl_readdatavalid) else $error("read answer not one cycle");
   a_ident_word: assert property (ctl_read && ctl_address == `REG_ID |=>
      ctl_readdata == {4'h0, `ID_TYPE, `ID_MAKER})
      else $error("identity word wrong");
   a_tool_words: assert property (ctl_read && ctl_address inside {1, 2, 3}
      |=> ctl_readdata == ($past(ctl_address) == `REG_CFG_A ? `CFG_A_VAL :
      $past(ctl_address) == `REG_CFG_B ? `CFG_B_VAL : `CFG_C_VAL))
      else $error("tooling word wrong");
   a_unmapped_zero: assert property (ctl_read && ctl_address > `REG_CTRL
      |=> ctl_readdata == 32'h0) else $error("unmapped word not zero");
   a_ctrl_readback: assert property (ctl_read && known_q &&
      ctl_address == `REG_CTRL |=> ctl_readdata == ctrl_q)
      else $error("control readback wrong");
   a_cap_hold: assert property (cap_valid && !cap_ready |=> cap_valid &&
      $stable(cap_data) && $stable(cap_sop) && $stable(cap_eop))
      else $error("capture word changed before accept");
   a_cap_framing: assert property (cap_valid |->
      cap_sop == (words_q == 4'h0) && words_q < 4'hC && cap_empty == 2'h0)
      else $error("capture framing wrong");
   a_disabled_quiet: assert property ($rose(cap_valid) && words_q == 4'h0
      && known_q |-> ctrl_q[0]) else $error("capture while disabled");
   a_reset_quiet: assert property (disable iff (!rst_n) !trace_rst_n |=>
      !cap_valid && !ctl_readdatavalid) else $error("debug reset ignored");
endmodule : video_tap_checker

// ===== tb/tb_video_stream_monitor_tap.sv
// self-checking bench: collector and monitor joined by their carrier
`timescale 1ns/1ps
`include "video_tap_consts.svh"
module tb_video_stream_monitor_tap;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [`APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd, ctrl_m, st;
   logic [`VID_W-1:0] din_data, dout_data;
   logic din_valid, din_sop, din_eop, din_ready;
   logic dout_valid, dout_sop, dout_eop, dout_ready;
   int errors, total_checks, cyc, nsmp, nst;
   int cnt[6];
   bit in_pkt, act;
   logic [31:0] smp_q[$];
   logic [33:0] exp_q[$];
   logic [31:0] modes[6] = '{32'h0000_0101, 32'h0000_0201, 32'h0000_0301,
      32'h0000_0300, 32'h0000_0001, 32'h0000_0301};
   int lens[6] = '{5, 8, 9, 7, 4, 1};
   video_tap_if tap_if();
   trace_collector trace_collector_i (.clk(clk), .rst_n(rst_n),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tap(tap_if));
   video_tap_monitor video_tap_monitor_i (.clk(clk), .tap(tap_if),
      .din_data(din_data), .din_valid(din_valid), .din_sop(din_sop),
      .din_eop(din_eop), .din_ready(din_ready), .dout_data(dout_data),
      .dout_valid(dout_valid), .dout_sop(dout_sop), .dout_eop(dout_eop),
      .dout_ready(dout_ready));
   video_tap_checker checker_i (.clk(clk), .rst_n(rst_n),
      .trace_rst_n(tap_if.trace_rst_n), .ctl_address(tap_if.ctl_address),
      .ctl_read(tap_if.ctl_read), .ctl_write(tap_if.ctl_write),
      .ctl_writedata(tap_if.ctl_writedata),
      .ctl_byteenable(tap_if.ctl_byteenable),
      .ctl_readdata(tap_if.ctl_readdata),
      .ctl_readdatavalid(tap_if.ctl_readdatavalid),
      .ctl_waitrequest(tap_if.ctl_waitrequest),
      .cap_data(tap_if.cap_data), .cap_valid(tap_if.cap_valid),
      .cap_ready(tap_if.cap_ready), .cap_sop(tap_if.cap_sop),
      .cap_eop(tap_if.cap_eop), .cap_empty(tap_if.cap_empty));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one idle edge before each setup keeps psel from being driven twice
   task automatic apb(input logic [7:0] a, input logic w,
      input logic [31:0] d);
      @(posedge clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (!pready);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // monitor word access through the collector's command registers
   task automatic mon(input logic [2:0] w, input logic wr,
      input logic [31:0] d);
      if (wr) begin
         apb(`APB_WDATA, 1'b1, d);
      end
      apb(`APB_CMD, 1'b1, {23'h0, wr, 5'h0, w});
      do begin
         apb(`APB_STATUS, 1'b0, 32'h0);
      end while (rd[0]);
      if (!wr) begin
         apb(`APB_RDATA, 1'b0, 32'h0);
      end
   endtask : mon
   // beats hold until taken; random gaps give the stall counters work
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         if ($urandom % 2) begin
            din_valid <= 1'b0;
            @(posedge clk);
         end
         din_data <= 24'($urandom);
         din_sop <= (i == 0);
         din_eop <= (i == n - 1);
         din_valid <= 1'b1;
         do @(posedge clk); while (!din_ready);
      end
      din_valid <= 1'b0;
   endtask : send
   // read back every expected capture word, then prove nothing more comes
   task automatic drain();
      do begin
         apb(`APB_STATUS, 1'b0, 32'h0);
         st = rd;
         if (st[1] && exp_q.size() > 0) begin
            apb(`APB_CAPTURE, 1'b0, 32'h0);
            chk({st[3:2], rd}, exp_q.pop_front());
            chk(34'(st[5:4]), 34'h0);
         end
      end while (exp_q.size() > 0);
      repeat (20) @(posedge clk);
      apb(`APB_STATUS, 1'b0, 32'h0);
      chk(34'(rd[1:0]), 34'h0);
   endtask : drain
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      dout_ready <= 1'($urandom);
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         $display("[ERR] %0t timeout", $time);
         stop_test();
      end
   end
   // reference model of the tap, sampled on the design's own edges
   always @(posedge clk) begin
      chk(34'({din_ready, dout_valid, dout_sop, dout_eop, dout_data}),
         34'({dout_ready, din_valid, din_sop, din_eop, din_data}));
      if (tap_if.trace_rst_n !== 1'b1) begin
         in_pkt = 1'b0;
         cnt = '{default: 0};
         smp_q.delete();
      end else begin
         act = in_pkt || (din_valid && din_sop);
         if (act) begin
            cnt[{!din_valid, !dout_ready}]++;
         end else if (din_valid != dout_ready) begin
            cnt[din_valid ? 4 : 5]++;
         end
         if (act && din_valid && dout_ready) begin
            if (smp_q.size() < 6) begin
               smp_q.push_back({8'h00, din_data});
            end
            if (din_eop) begin
               nst = ctrl_m[8] ? 6 : 0;
               nsmp = ctrl_m[9] ? smp_q.size() : 0;
               for (int i = 0; ctrl_m[0] && i < nst + nsmp; i++) begin
                  exp_q.push_back({i == 0, i == nst + nsmp - 1,
                     i < nst ? 32'(cnt[i]) : smp_q[i - nst]});
               end
               in_pkt = 1'b0;
               cnt = '{default: 0};
               smp_q.delete();
            end else if (din_sop) begin
               in_pkt = 1'b1;
            end
         end
      end
   end
   initial begin
      void'($urandom(32'hB6B1));
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      din_valid = 1'b0;
      din_sop = 1'b0;
      din_eop = 1'b0;
      din_data = '0;
      ctrl_m = 32'h0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      // identity must survive a write; control reads zero after reset
      mon(`REG_ID, 1'b1, 32'hFFFF_FFFF);
      for (int i = 0; i < 8; i++) begin
         mon(3'(i), 1'b0, 32'h0);
         st = i == 1 ? `CFG_A_VAL : i == 2 ? `CFG_B_VAL :
            i == 3 ? `CFG_C_VAL : 32'h0;
         chk(rd, i == 0 ? {4'h0, `ID_TYPE, `ID_MAKER} : st);
      end
      $display("test register words done");
      foreach (modes[t]) begin
         if (t == 5) begin
            // debug reset mid-run: stream keeps flowing, nothing captured
            apb(`APB_SOFTRST, 1'b1, 32'h1);
            ctrl_m = 32'h0;
            send(3);
            drain();
            apb(`APB_SOFTRST, 1'b1, 32'h0);
            mon(`REG_CTRL, 1'b0, 32'h0);
            chk(rd, 32'h0);
         end
         ctrl_m = modes[t] | ($urandom & 32'hFFFF_FCFE);
         mon(`REG_CTRL, 1'b1, ctrl_m);
         mon(`REG_CTRL, 1'b0, 32'h0);
         chk(rd, ctrl_m & 32'h0000_0301);
         send(lens[t]);
         drain();
         $display("test %0d done", t);
      end
      stop_test();
   end
endmodule : tb_video_stream_monitor_tap
